// [logic/pdlr_port.sv]
// top: ahb-lite register slave for one 8-bit port's drive enable and drive level
// Contract
// R1 - enable bit 1 drives pin, 0 input-only
// R2 - input buffer follows sense field, not enable
// R3 - enable-set write sets bits written one
// R4 - enable-clear write clears bits written one
// R5 - enable-flip write inverts bits written one
// R6 - enable companions read back current enable mask
// R7 - level bit gives driven value high/low
// R8 - level drives pin only while enabled
// R9 - level-set write sets bits written one
// R10 - level-clear write clears bits written one
// R11 - level companions read back current level
// R12 - writes land at data-phase end; reset zero
module pdlr_port (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [pdlr_pkg::PINS-1:0] i_pin_in,
  output logic [pdlr_pkg::PINS-1:0] o_pin_out,
  output logic [pdlr_pkg::PINS-1:0] o_pin_oe,
  output logic [pdlr_pkg::PINS-1:0] o_pin_in_en
);

  typedef struct packed {
    pdlr_pkg::pdlr_phase_t phase;
    logic [5:0] wr_idx;
    logic [pdlr_pkg::PINS-1:0] drive_enable;
    logic [pdlr_pkg::PINS-1:0] drive_level;
    logic [pdlr_pkg::SENSE_TOTAL_W-1:0] sense_config;
    logic [31:0] rdata;
  } pdlr_state_t;

  localparam pdlr_state_t STATE_RESET = '{
    phase: pdlr_pkg::PDLR_PH_IDLE,
    wr_idx: pdlr_pkg::IDX_DRIVE_ENABLE,
    drive_enable: pdlr_pkg::DRIVE_ENABLE_RESET,
    drive_level: pdlr_pkg::DRIVE_LEVEL_RESET,
    sense_config: pdlr_pkg::SENSE_CONFIG_RESET,
    rdata: pdlr_pkg::RDATA_RESET
  };

  pdlr_state_t s_q;
  pdlr_state_t s_d;
  logic [pdlr_pkg::PINS-1:0] pin_level;
  logic [pdlr_pkg::PINS-1:0] buf_en;
  logic addr_phase;
  logic [5:0] addr_idx;
  logic [pdlr_pkg::PINS-1:0] wr_byte;
  pdlr_pkg::pdlr_op_t enable_op;
  pdlr_pkg::pdlr_op_t level_op;
  logic sense_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // register index carried by a byte address; the low two bits are ignored
  function automatic logic [5:0] reg_index(input logic [31:0] addr);
    reg_index = addr[pdlr_pkg::IDX_MSB:pdlr_pkg::IDX_LSB];
  endfunction

  // one mask update rule shared by the enable and the level mask
  function automatic logic [pdlr_pkg::PINS-1:0] mask_update(
    input logic [pdlr_pkg::PINS-1:0] cur,
    input logic [pdlr_pkg::PINS-1:0] data,
    input pdlr_pkg::pdlr_op_t op
  );
    logic [pdlr_pkg::PINS-1:0] res;
    res = cur;
    case (op)
      pdlr_pkg::PDLR_OP_LOAD: begin
        res = data;
      end
      pdlr_pkg::PDLR_OP_SET: begin
        res = cur | data;
      end
      pdlr_pkg::PDLR_OP_CLEAR: begin
        res = cur & ~data;
      end
      pdlr_pkg::PDLR_OP_FLIP: begin
        res = cur ^ data;
      end
      default: begin
        res = cur;
      end
    endcase
    mask_update = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // input path

  pdlr_pin_sense u_pin_sense (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin_level(i_pin_in),
    .i_sense_config(s_q.sense_config),
    .o_buf_en(buf_en),
    .o_level(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // address phase qualification

  // only whole-word transfers are taken; anything else is an idle cycle
  always_comb begin
    addr_phase = i_hsel
                 && i_hready
                 && ((i_htrans == pdlr_pkg::HTRANS_NONSEQ) || (i_htrans == pdlr_pkg::HTRANS_SEQ))
                 && (i_hsize == pdlr_pkg::HSIZE_WORD);
    addr_idx = reg_index(i_haddr);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write decode for the pending data phase

  always_comb begin
    wr_byte = i_hwdata[pdlr_pkg::PINS-1:0];
    enable_op = pdlr_pkg::PDLR_OP_KEEP;
    level_op = pdlr_pkg::PDLR_OP_KEEP;
    sense_wr = 1'b0;
    if (s_q.phase == pdlr_pkg::PDLR_PH_WRITE) begin
      if (s_q.wr_idx == pdlr_pkg::IDX_DRIVE_ENABLE) begin
        enable_op = pdlr_pkg::PDLR_OP_LOAD; // R1
      end else if (s_q.wr_idx == pdlr_pkg::IDX_DRIVE_ENABLE_SET) begin
        enable_op = pdlr_pkg::PDLR_OP_SET; // R3
      end else if (s_q.wr_idx == pdlr_pkg::IDX_DRIVE_ENABLE_CLEAR) begin
        enable_op = pdlr_pkg::PDLR_OP_CLEAR; // R4
      end else if (s_q.wr_idx == pdlr_pkg::IDX_DRIVE_ENABLE_FLIP) begin
        enable_op = pdlr_pkg::PDLR_OP_FLIP; // R5
      end else if (s_q.wr_idx == pdlr_pkg::IDX_DRIVE_LEVEL) begin
        level_op = pdlr_pkg::PDLR_OP_LOAD; // R7
      end else if (s_q.wr_idx == pdlr_pkg::IDX_DRIVE_LEVEL_SET) begin
        level_op = pdlr_pkg::PDLR_OP_SET; // R9
      end else if (s_q.wr_idx == pdlr_pkg::IDX_DRIVE_LEVEL_CLEAR) begin
        level_op = pdlr_pkg::PDLR_OP_CLEAR; // R10
      end else if (s_q.wr_idx == pdlr_pkg::IDX_SENSE_CONFIG) begin
        sense_wr = 1'b1;
      end
      // pin level index is read-only and unmapped indices drop the write
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;

    // data phase of a write completes this edge because the slave never stalls
    s_d.drive_enable = mask_update(s_q.drive_enable, wr_byte, enable_op); // R12
    s_d.drive_level = mask_update(s_q.drive_level, wr_byte, level_op); // R12
    if (sense_wr) begin
      s_d.sense_config = i_hwdata[pdlr_pkg::SENSE_TOTAL_W-1:0];
    end

    s_d.phase = pdlr_pkg::PDLR_PH_IDLE;
    if (addr_phase) begin
      if (i_hwrite) begin
        s_d.phase = pdlr_pkg::PDLR_PH_WRITE;
        s_d.wr_idx = addr_idx;
      end else begin
        // read from the post-write view so a read right after a write sees it
        s_d.rdata = '0;
        if (addr_idx == pdlr_pkg::IDX_DRIVE_ENABLE) begin
          s_d.rdata[pdlr_pkg::PINS-1:0] = s_d.drive_enable;
        end else if (addr_idx == pdlr_pkg::IDX_DRIVE_ENABLE_SET) begin
          s_d.rdata[pdlr_pkg::PINS-1:0] = s_d.drive_enable; // R6
        end else if (addr_idx == pdlr_pkg::IDX_DRIVE_ENABLE_CLEAR) begin
          s_d.rdata[pdlr_pkg::PINS-1:0] = s_d.drive_enable; // R6
        end else if (addr_idx == pdlr_pkg::IDX_DRIVE_ENABLE_FLIP) begin
          s_d.rdata[pdlr_pkg::PINS-1:0] = s_d.drive_enable; // R6
        end else if (addr_idx == pdlr_pkg::IDX_DRIVE_LEVEL) begin
          s_d.rdata[pdlr_pkg::PINS-1:0] = s_d.drive_level;
        end else if (addr_idx == pdlr_pkg::IDX_DRIVE_LEVEL_SET) begin
          s_d.rdata[pdlr_pkg::PINS-1:0] = s_d.drive_level; // R11
        end else if (addr_idx == pdlr_pkg::IDX_DRIVE_LEVEL_CLEAR) begin
          s_d.rdata[pdlr_pkg::PINS-1:0] = s_d.drive_level; // R11
        end else if (addr_idx == pdlr_pkg::IDX_PIN_LEVEL) begin
          s_d.rdata[pdlr_pkg::PINS-1:0] = pin_level;
        end else if (addr_idx == pdlr_pkg::IDX_SENSE_CONFIG) begin
          s_d.rdata[pdlr_pkg::SENSE_TOTAL_W-1:0] = s_d.sense_config;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= STATE_RESET; // R12
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states: every data phase finishes in one cycle, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = pdlr_pkg::HRESP_OKAY;
  assign o_hrdata = s_q.rdata;

  // the level is always presented; the pad only drives it while oe is high
  assign o_pin_oe = s_q.drive_enable; // R1
  assign o_pin_out = s_q.drive_level; // R7 R8
  assign o_pin_in_en = buf_en; // R2

endmodule

// [logic/pdlr_pkg.sv]
// package: register map, field layout and bus encodings for the port drive register block
package pdlr_pkg;

  // port geometry
  localparam int unsigned PINS = 8;
  localparam int unsigned SENSE_W = 3;
  localparam int unsigned SENSE_TOTAL_W = PINS * SENSE_W;

  // register indices; the byte address of a register is four times its index
  localparam logic [5:0] IDX_DRIVE_ENABLE = 6'h00;
  localparam logic [5:0] IDX_DRIVE_ENABLE_SET = 6'h01;
  localparam logic [5:0] IDX_DRIVE_ENABLE_CLEAR = 6'h02;
  localparam logic [5:0] IDX_DRIVE_ENABLE_FLIP = 6'h03;
  localparam logic [5:0] IDX_DRIVE_LEVEL = 6'h04;
  localparam logic [5:0] IDX_DRIVE_LEVEL_SET = 6'h05;
  localparam logic [5:0] IDX_DRIVE_LEVEL_CLEAR = 6'h06;
  localparam logic [5:0] IDX_PIN_LEVEL = 6'h08;
  localparam logic [5:0] IDX_SENSE_CONFIG = 6'h10;

  // byte address bits that carry the index
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 7;

  // reset values
  localparam logic [PINS-1:0] DRIVE_ENABLE_RESET = 8'h00;
  localparam logic [PINS-1:0] DRIVE_LEVEL_RESET = 8'h00;
  localparam logic [SENSE_TOTAL_W-1:0] SENSE_CONFIG_RESET = 24'h00_0000;
  localparam logic [PINS-1:0] PIN_LEVEL_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // sense configuration code that switches the digital input buffer off
  localparam logic [SENSE_W-1:0] SENSE_INPUT_DISABLE = 3'h4;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // how a write acts on an 8-bit mask
  typedef enum logic [2:0] {
    PDLR_OP_KEEP = 3'b000,
    PDLR_OP_LOAD = 3'b001,
    PDLR_OP_SET = 3'b010,
    PDLR_OP_CLEAR = 3'b011,
    PDLR_OP_FLIP = 3'b100
  } pdlr_op_t;

  // bus data phase
  typedef enum logic {
    PDLR_PH_IDLE = 1'b0,
    PDLR_PH_WRITE = 1'b1
  } pdlr_phase_t;

endpackage

// [logic/pdlr_pin_sense.sv]
// pin input path: two-stage synchroniser and sense-configured input buffer gating
module pdlr_pin_sense (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [pdlr_pkg::PINS-1:0] i_pin_level,
  input wire logic [pdlr_pkg::SENSE_TOTAL_W-1:0] i_sense_config,
  output logic [pdlr_pkg::PINS-1:0] o_buf_en,
  output logic [pdlr_pkg::PINS-1:0] o_level
);

  typedef struct packed {
    logic [pdlr_pkg::PINS-1:0] sync1;
    logic [pdlr_pkg::PINS-1:0] sync2;
    logic [pdlr_pkg::PINS-1:0] level;
  } pdlr_sense_state_t;

  pdlr_sense_state_t s_q;
  pdlr_sense_state_t s_d;
  logic [pdlr_pkg::PINS-1:0] buf_en;

  ////////////////////////////////////////////////////////////////////////////////
  // buffer enable depends on the sense field alone, never on the drive mask
  always_comb begin
    for (int n = 0; n < pdlr_pkg::PINS; n++) begin
      buf_en[n] = (i_sense_config[n*pdlr_pkg::SENSE_W +: pdlr_pkg::SENSE_W]
                   != pdlr_pkg::SENSE_INPUT_DISABLE); // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.sync1 = i_pin_level;
    s_d.sync2 = s_q.sync1;
    // a disabled buffer freezes the sampled value instead of forcing zero
    for (int n = 0; n < pdlr_pkg::PINS; n++) begin
      if (buf_en[n]) begin
        s_d.level[n] = s_q.sync2[n]; // R2
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_buf_en = buf_en;
  assign o_level = s_q.level;

endmodule

// [dv/pdlr_port_props.sv]
// checker: bus write and read relations of the port drive register block
module pdlr_port_props (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire logic [7:0] o_pin_in_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ap;
  logic wp_q;
  logic rp_q;
  logic [5:0] idx_q;
  logic [7:0] wd_q;
  assign ap = i_hsel & i_hready & i_htrans[1] & (i_hsize == 3'h2);
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      idx_q <= 6'h00;
      wd_q <= 8'h00;
    end else begin
      wp_q <= ap & i_hwrite;
      rp_q <= ap & ~i_hwrite;
      idx_q <= i_haddr[7:2];
      wd_q <= i_hwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr(logic [5:0] n);
    wp_q && idx_q == n;
  endsequence
  chk_en_load: assert property (s_wr(6'h00) |=> o_pin_oe == wd_q)
    else $error("enable load wrong");
  chk_en_set: assert property (s_wr(6'h01) |=> o_pin_oe == ($past(o_pin_oe) | wd_q))
    else $error("enable set wrong");
  chk_en_clear: assert property (s_wr(6'h02) |=> o_pin_oe == ($past(o_pin_oe) & ~wd_q))
    else $error("enable clear wrong");
  chk_en_flip: assert property (s_wr(6'h03) |=> o_pin_oe == ($past(o_pin_oe) ^ wd_q))
    else $error("enable flip wrong");
  chk_lvl_load: assert property (s_wr(6'h04) |=> o_pin_out == wd_q)
    else $error("level load wrong");
  chk_lvl_set: assert property (s_wr(6'h05) |=> o_pin_out == ($past(o_pin_out) | wd_q))
    else $error("level set wrong");
  chk_lvl_clear: assert property (s_wr(6'h06) |=> o_pin_out == ($past(o_pin_out) & ~wd_q))
    else $error("level clear wrong");
  chk_en_hold: assert property (!(wp_q && idx_q < 6'h04) |=> $stable(o_pin_oe))
    else $error("enable changed without write");
  chk_rd_enable: assert property (rp_q && idx_q < 6'h04 |-> o_hrdata == {24'h0, o_pin_oe})
    else $error("enable read wrong");
  chk_rd_level: assert property (rp_q && idx_q inside {[6'h04:6'h06]}
    |-> o_hrdata == {24'h0, o_pin_out})
    else $error("level read wrong");
  chk_inbuf_apart: assert property ($changed(o_pin_oe) |-> $stable(o_pin_in_en))
    else $error("input buffer moved with enable");
endmodule
bind pdlr_port pdlr_port_props pdlr_port_props_inst (.i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .o_pin_in_en(o_pin_in_en));

// [dv/tb_pdlr_port.sv]
// testbench: register walk, read-back and reset checks for the port drive block
module tb_pdlr_port;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [5:0] idx; logic [31:0] wd; logic [7:0] oe; logic [7:0] out;} pdlr_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic hresp;
  logic [7:0] pin_in = 8'h5a;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pin_in_en;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  pdlr_row_t rows [9] = '{
    '{6'h00, 32'h0000_00a5, 8'ha5, 8'h00}, '{6'h01, 32'h0000_000a, 8'haf, 8'h00},
    '{6'h02, 32'h0000_0021, 8'h8e, 8'h00}, '{6'h03, 32'h0000_00f0, 8'h7e, 8'h00},
    '{6'h01, 32'h0000_0000, 8'h7e, 8'h00}, '{6'h04, 32'h0000_003c, 8'h7e, 8'h3c},
    '{6'h05, 32'h0000_0081, 8'h7e, 8'hbd}, '{6'h06, 32'hffff_ff0c, 8'h7e, 8'hb1},
    '{6'h03, 32'h0000_0083, 8'hfd, 8'hb1}};
  pdlr_port pdlr_port_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(pdlr_pkg::HSIZE_WORD), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_in_en(pin_in_en));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single word transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= pdlr_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h00_0000, idx, 2'b00};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
    #1;
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("rst oe", {24'h0, pin_oe}, 32'h0000_0000);
    chk("rst out", {24'h0, pin_out}, 32'h0000_0000);
    foreach (rows[k]) begin
      bus(1'b1, rows[k].idx, rows[k].wd);
      chk("oe", {24'h0, pin_oe}, {24'h0, rows[k].oe});
      chk("out", {24'h0, pin_out}, {24'h0, rows[k].out});
      bus(1'b0, rows[k].idx, 32'h0000_0000);
      chk("rd", rd, {24'h0, rows[k].idx < 6'h04 ? rows[k].oe : rows[k].out});
    end
    // unmapped place: write dropped, read gives zero
    bus(1'b1, 6'h07, 32'h0000_00ff);
    chk("unmapped out", {24'h0, pin_out}, 32'h0000_00b1);
    bus(1'b0, 6'h07, 32'h0000_0000);
    chk("unmapped rd", rd, 32'h0000_0000);
    bus(1'b1, 6'h00, 32'h0000_0000);
    bus(1'b0, 6'h05, 32'h0000_0000);
    chk("held level", rd, 32'h0000_00b1);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("mid rst out", {24'h0, pin_out}, 32'h0000_0000);
    bus(1'b1, 6'h10, 32'h0000_0004);
    bus(1'b1, 6'h01, 32'h0000_00ff);
    chk("in buffer", {24'h0, pin_in_en}, 32'h0000_00fe);
    chk("oe all", {24'h0, pin_oe}, 32'h0000_00ff);
    // pin 0 has its buffer off, so its sampled bit must stay at the old low level
    @(posedge clk);
    pin_in <= 8'ha5;
    repeat (3) @(posedge clk);
    bus(1'b0, 6'h08, 32'h0000_0000);
    chk("pin level", rd, 32'h0000_00a4);
    finish_test();
  end
endmodule
